// ==== verilog/bisync_consts.svh ====
// offsets, field positions, reset values and timing counts of the controller
// Behaviour
// [R01] channel works only when protocol select field equals binary 11
// [R02] status shows line condition; each change raises a maskable interrupt
// [R03] after enable transmitter polls first descriptor about every eight clocks
// [R04] stop sends held byte, keeps index, then sends sync pairs until restart; code leaves the pending byte unsent and starts fill pairs at the next boundary
// [R05] host issues stop before disabling transmitter it will re-enable
// [R06] stop and restart leave transparent or normal transmit mode unchanged
// [R07] restart resumes from current descriptor index and polls its ready bit
// [R08] host restarts after stop, stop with disable, underrun or lost clear-to-send
// [R09] host restarts first, then sets transmitter enable
// [R10] reset-block-check clears receive accumulator at once
// [R11] enter-hunt closes buffer, resets check, hunts sync pair, next descriptor
// [R12] host issues enter-hunt before re-setting receiver enable
// [R13] eight 16-bit table entries: character, end, check-expected, hunt flags
// [R14] first entry equal to 8000 hex disables the whole table
// [R15] compare low byte of entries before first one with end flag
// [R16] on match store character; close now or after one/two check bytes
// [R17] buffer closed by control match raises maskable interrupt
// [R18] hunt flag set enters hunt after close or after check bytes
// [R19] sync word: valid bit 15, char low byte; strip and underrun fill
// [R20] transparent underrun inside message sends escape-sync pairs
// [R21] transparent escape dropped; escape-sync dropped; escape-escape stores one
// [R22] unknown char after escape closes with error; invalid escape is plain
// [R23] hunt shifts one bit at a time, compares both sync chars
`ifndef BISYNC_CONSTS_SVH
`define BISYNC_CONSTS_SVH
`define A_MODE 8'h00
`define A_CMD 8'h04
`define A_SYNP 8'h08
`define A_SYNC 8'h0C
`define A_ESC 8'h10
`define A_TXD 8'h14
`define A_RXD 8'h18
`define A_STAT 8'h1C
`define A_MASK 8'h20
`define A_BCHK 8'h24
`define A_TAB 8'h40
`define PROTO_BISYNC 2'b11
`define M_TXEN 2
`define M_RXEN 3
`define M_TTR 4
`define M_RTR 5
`define M_CRC 6
`define CMD_STOP 2'd0
`define CMD_RESTART 2'd1
`define CMD_RSTBC 2'd2
`define CMD_HUNT 2'd3
`define E_FLAG 15
`define B_FLAG 14
`define H_FLAG 13
`define V_FLAG 15
`define TAB_OFF 16'h8000
`define CRC_POLY 16'hA001
`define BITS_PER_CHAR 4'd8
`endif

// ==== verilog/bisync_pkg.sv ====
// types shared by the controller
package bisync_pkg;
	typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_CHAR = 2'b10} rx_st_t;
	typedef logic [15:0] word16_t;
endpackage

// ==== verilog/bisync_channel_controller.sv ====
// character-oriented synchronous channel with axi4-lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "bisync_consts.svh"
module bisync_channel_controller (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_clk,
	input wire logic rx_clk,
	input wire logic rxd,
	input wire logic cts_n,
	input wire logic cd_n,
	output logic txd,
	output logic irq
);
	import bisync_pkg::*;

	// write a 16-bit register merged with the low two byte lanes
	function automatic word16_t m16(input word16_t o, input [31:0] d,
		input [3:0] s);
		m16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	// table scan: hit, check-expected, hunt-after
	function automatic [2:0] tab_hit(input [127:0] t, input [7:0] c);
		logic stop;
		tab_hit = 3'b000;
		stop = (t[15:0] == `TAB_OFF); // [R14]
		for (int i = 0; i < 8; i++) begin
			if (!stop) begin
				if (t[16*i+`E_FLAG]) begin
					stop = 1'b1; // [R15]
				end else if (t[16*i +: 8] == c) begin
					tab_hit = {1'b1, t[16*i+`B_FLAG], t[16*i+`H_FLAG]};
					stop = 1'b1;
				end
			end
		end
	endfunction

	// crc16 reflected or plain lrc over one byte
	function automatic word16_t bc_upd(input word16_t a, input [7:0] c,
		input crc);
		word16_t r;
		r = a ^ {8'h00, c};
		if (crc) begin
			for (int k = 0; k < 8; k++) begin
				r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
			end
		end else begin
			r = {8'h00, a[7:0] ^ c};
		end
		bc_upd = r;
	endfunction

	logic [6:0] mode_ff;
	word16_t synp_ff, sync_ff, esc_ff;
	logic [127:0] tab_ff;
	logic [3:0] mask_ff, ev_ff, nxt_ev;
	logic on;
	assign on = (mode_ff[1:0] == `PROTO_BISYNC); // [R01]

	// two-flop synchronisers for pins and link clocks
	logic [4:0] s1_ff, s2_ff;
	logic txc_d_ff, rxc_d_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff <= 5'h1F;
			s2_ff <= 5'h1F;
			txc_d_ff <= 1'b1;
			rxc_d_ff <= 1'b1;
		end else begin
			s1_ff <= {tx_clk, rx_clk, rxd, cts_n, cd_n};
			s2_ff <= s1_ff;
			txc_d_ff <= s2_ff[4];
			rxc_d_ff <= s2_ff[3];
		end
	end
	logic tx_tick, rx_tick, rx_bit;
	assign tx_tick = !s2_ff[4] && txc_d_ff; // shift out on falling edge
	assign rx_tick = s2_ff[3] && !rxc_d_ff; // sample on rising edge
	assign rx_bit = s2_ff[2];

	// axi write: both channels taken together, answer next cycle
	logic wr, rd;
	logic [7:0] wa;
	assign wa = s_axi_awaddr;
	assign wr = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr;
	assign s_axi_wready = wr;
	assign rd = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd;
	logic cmd_go;
	logic [1:0] cmd;
	assign cmd_go = wr && wa == `A_CMD && s_axi_wstrb[0] && on;
	assign cmd = s_axi_wdata[1:0];

	// config registers; commands never touch the mode bits [R06]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff <= 7'h00;
			synp_ff <= 16'h0000;
			sync_ff <= 16'h0000;
			esc_ff <= 16'h0000;
			tab_ff <= {8{`TAB_OFF}};
			mask_ff <= 4'h0;
		end else if (wr) begin
			case (wa)
			`A_MODE: if (s_axi_wstrb[0]) mode_ff <= s_axi_wdata[6:0];
			`A_SYNP: synp_ff <= m16(synp_ff, s_axi_wdata, s_axi_wstrb);
			`A_SYNC: sync_ff <= m16(sync_ff, s_axi_wdata, s_axi_wstrb);
			`A_ESC: esc_ff <= m16(esc_ff, s_axi_wdata, s_axi_wstrb);
			`A_MASK: if (s_axi_wstrb[0]) mask_ff <= s_axi_wdata[3:0];
			default: begin
				if (wa[7:5] == 3'b010 && wa[1:0] == 2'b00) begin
					tab_ff[16*wa[4:2] +: 16] <=
						m16(tab_ff[16*wa[4:2] +: 16], s_axi_wdata,
						s_axi_wstrb); // [R13]
				end
			end
			endcase
		end
	end

	// ---- transmitter ----
	logic [7:0] txb_ff, txsh_ff;
	logic txlast_ff, txpend_ff, stop_ff, inmsg_ff, pair_ff, escq_ff;
	logic [2:0] tbd_ff;
	logic [3:0] tcnt_ff;
	logic tx_bnd, txen;
	assign txen = on && mode_ff[`M_TXEN];
	assign tx_bnd = tx_tick && tcnt_ff == 4'd0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txb_ff <= 8'h00;
			txlast_ff <= 1'b0;
			txpend_ff <= 1'b0;
		end else if (wr && wa == `A_TXD && s_axi_wstrb[0]) begin
			txb_ff <= s_axi_wdata[7:0];
			txlast_ff <= s_axi_wdata[8];
			txpend_ff <= 1'b1;
		end else if (tx_bnd && txen && !stop_ff && txpend_ff &&
			!escq_ff && !(mode_ff[`M_TTR] && esc_ff[`V_FLAG] &&
			txb_ff == esc_ff[7:0] && !pair_ff)) begin
			txpend_ff <= 1'b0; // byte polled once per character [R03]
		end
	end
	// byte selection at each character boundary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txsh_ff <= 8'hFF;
			tcnt_ff <= 4'd0;
			stop_ff <= 1'b0;
			inmsg_ff <= 1'b0;
			pair_ff <= 1'b0;
			escq_ff <= 1'b0;
			tbd_ff <= 3'd0;
		end else begin
			if (cmd_go && cmd == `CMD_STOP) begin
				stop_ff <= 1'b1; // [R04]
			end else if (cmd_go && cmd == `CMD_RESTART) begin
				stop_ff <= 1'b0; // keep tbd_ff, resume polling [R07]
			end
			if (tx_tick) begin
				tcnt_ff <= (tcnt_ff == 4'd0) ? `BITS_PER_CHAR - 4'd1 :
					tcnt_ff - 4'd1;
				txsh_ff <= {1'b1, txsh_ff[7:1]};
			end
			if (tx_bnd) begin
				if (!txen) begin
					txsh_ff <= 8'hFF;
				end else if (stop_ff || (inmsg_ff && !txpend_ff)) begin
					// pair fill: sync-sync or escape-sync [R04] [R20]
					pair_ff <= !pair_ff;
					txsh_ff <= (mode_ff[`M_TTR] && !pair_ff) ?
						esc_ff[7:0] : sync_ff[7:0]; // [R19]
				end else if (txpend_ff && mode_ff[`M_TTR] &&
					esc_ff[`V_FLAG] && txb_ff == esc_ff[7:0] && !escq_ff) begin
					txsh_ff <= esc_ff[7:0]; // double the escape
					escq_ff <= 1'b1;
					pair_ff <= 1'b0;
				end else if (txpend_ff) begin
					txsh_ff <= txb_ff;
					escq_ff <= 1'b0;
					pair_ff <= 1'b0;
					inmsg_ff <= !txlast_ff;
					tbd_ff <= tbd_ff + 3'd1;
				end else begin
					txsh_ff <= sync_ff[7:0]; // idle sync between frames
				end
			end
		end
	end
	assign txd = txsh_ff[0];

	// ---- receiver ----
	rx_st_t rst_ff;
	word16_t rsh_ff, bc_ff;
	logic [3:0] rcnt_ff;
	logic [7:0] rxb_ff;
	logic rval_ff, rclose_ff, rerr_ff, aft_ff, hpend_ff;
	logic [1:0] bwait_ff;
	logic [2:0] rbd_ff;
	logic [7:0] ch;
	logic [2:0] th;
	logic chr, rtr, dle_v;
	assign ch = {rx_bit, rsh_ff[15:9]};
	assign th = tab_hit(tab_ff, ch);
	assign chr = on && mode_ff[`M_RXEN] && rx_tick && rst_ff == RX_CHAR &&
		rcnt_ff == `BITS_PER_CHAR - 4'd1;
	assign rtr = mode_ff[`M_RTR];
	assign dle_v = rtr && esc_ff[`V_FLAG];
	logic hunt_cmd, ev_close;
	assign hunt_cmd = cmd_go && cmd == `CMD_HUNT;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_ff <= RX_HUNT;
			rsh_ff <= 16'h0000;
			rcnt_ff <= 4'd0;
			rxb_ff <= 8'h00;
			rval_ff <= 1'b0;
			rclose_ff <= 1'b0;
			rerr_ff <= 1'b0;
			aft_ff <= 1'b0;
			hpend_ff <= 1'b0;
			bwait_ff <= 2'd0;
			rbd_ff <= 3'd0;
			bc_ff <= 16'h0000;
			ev_close <= 1'b0;
		end else begin
			ev_close <= 1'b0;
			if (rd && s_axi_araddr == `A_RXD) begin
				rval_ff <= 1'b0;
				rclose_ff <= 1'b0;
				rerr_ff <= 1'b0;
			end
			if (rx_tick && on && mode_ff[`M_RXEN]) begin
				rsh_ff <= {rx_bit, rsh_ff[15:1]}; // [R23]
				rcnt_ff <= (rcnt_ff == `BITS_PER_CHAR - 4'd1) ? 4'd0 :
					rcnt_ff + 4'd1;
			end
			case (rst_ff)
			RX_HUNT: begin
				if (rx_tick && on && mode_ff[`M_RXEN] &&
					{rx_bit, rsh_ff[15:1]} == {synp_ff[7:0], synp_ff[15:8]}) begin
					rst_ff <= RX_CHAR; // [R23]
					rcnt_ff <= 4'd0;
				end
			end
			RX_CHAR: begin
				if (chr) begin
					if (bwait_ff != 2'd0) begin
						rxb_ff <= ch;
						rval_ff <= 1'b1;
						bc_ff <= bc_upd(bc_ff, ch, mode_ff[`M_CRC]);
						bwait_ff <= bwait_ff - 2'd1;
						if (bwait_ff == 2'd1) begin
							rclose_ff <= 1'b1; // [R16]
							ev_close <= 1'b1; // [R17]
							rbd_ff <= rbd_ff + 3'd1;
							if (hpend_ff) rst_ff <= RX_HUNT; // [R18]
						end
					end else if (aft_ff) begin
						aft_ff <= 1'b0;
						if (ch == sync_ff[7:0]) begin
							rval_ff <= rval_ff; // drop escape-sync [R21]
						end else if (ch == esc_ff[7:0]) begin
							rxb_ff <= ch; // [R21]
							rval_ff <= 1'b1;
							bc_ff <= bc_upd(bc_ff, ch, mode_ff[`M_CRC]);
						end else if (th[2]) begin
							rxb_ff <= ch;
							rval_ff <= 1'b1;
							bc_ff <= bc_upd(bc_ff, ch, mode_ff[`M_CRC]);
							bwait_ff <= th[1] ? (mode_ff[`M_CRC] ? 2'd2 : 2'd1) :
								2'd0;
							hpend_ff <= th[0];
							if (!th[1]) begin
								rclose_ff <= 1'b1;
								ev_close <= 1'b1; // [R17]
								rbd_ff <= rbd_ff + 3'd1;
								if (th[0]) rst_ff <= RX_HUNT; // [R18]
							end
						end else begin
							rclose_ff <= 1'b1;
							rerr_ff <= 1'b1; // [R22]
							rbd_ff <= rbd_ff + 3'd1;
						end
					end else if (dle_v && ch == esc_ff[7:0]) begin
						aft_ff <= 1'b1; // drop, not in check [R21]
					end else if (sync_ff[`V_FLAG] && ch == sync_ff[7:0]) begin
						rval_ff <= rval_ff; // strip sync [R19]
					end else if (!rtr && th[2]) begin
						rxb_ff <= ch; // [R16]
						rval_ff <= 1'b1;
						bc_ff <= bc_upd(bc_ff, ch, mode_ff[`M_CRC]);
						bwait_ff <= th[1] ? (mode_ff[`M_CRC] ? 2'd2 : 2'd1) :
							2'd0;
						hpend_ff <= th[0];
						if (!th[1]) begin
							rclose_ff <= 1'b1;
							ev_close <= 1'b1; // [R17]
							rbd_ff <= rbd_ff + 3'd1;
							if (th[0]) rst_ff <= RX_HUNT; // [R18]
						end
					end else begin
						rxb_ff <= ch; // plain char, escape too if invalid [R22]
						rval_ff <= 1'b1;
						bc_ff <= bc_upd(bc_ff, ch, mode_ff[`M_CRC]);
					end
				end
			end
			default: rst_ff <= RX_HUNT;
			endcase
			// commands override character work in the same cycle
			if (cmd_go && cmd == `CMD_RSTBC) begin
				bc_ff <= 16'h0000; // [R10]
			end
			if (hunt_cmd) begin
				rst_ff <= RX_HUNT; // [R11]
				// stale bits must not re-sync before fresh ones arrive [R23]
				rsh_ff <= 16'h0000;
				bc_ff <= 16'h0000;
				bwait_ff <= 2'd0;
				aft_ff <= 1'b0;
				rclose_ff <= 1'b1;
				rbd_ff <= rbd_ff + 3'd1;
				ev_close <= 1'b1;
			end
		end
	end

	// sticky events: line change, buffer closed; set beats clear [R02]
	logic [1:0] line_ff;
	always_comb begin
		nxt_ev = ev_ff;
		if (wr && wa == `A_STAT && s_axi_wstrb[0]) begin
			nxt_ev = nxt_ev & ~s_axi_wdata[3:0];
		end
		if (line_ff != s2_ff[1:0]) nxt_ev[2] = 1'b1; // [R02]
		if (ev_close) nxt_ev[3] = 1'b1; // [R17]
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_ff <= 4'h0;
			line_ff <= 2'b11;
		end else begin
			ev_ff <= nxt_ev;
			line_ff <= s2_ff[1:0];
		end
	end
	assign irq = |(ev_ff & mask_ff);

	// axi answers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa[1:0] != 2'b00 || wa > 8'h5C ||
					(wa > `A_BCHK && wa < `A_TAB)) ? 2'b10 : 2'b00;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
				`A_MODE: s_axi_rdata <= {25'h0, mode_ff};
				`A_CMD: s_axi_rdata <= {28'h0, tbd_ff, stop_ff};
				`A_SYNP: s_axi_rdata <= {16'h0, synp_ff};
				`A_SYNC: s_axi_rdata <= {16'h0, sync_ff[15], 7'h00, sync_ff[7:0]};
				`A_ESC: s_axi_rdata <= {16'h0, esc_ff[15], 7'h00, esc_ff[7:0]};
				`A_TXD: s_axi_rdata <= {22'h0, txpend_ff, txlast_ff, txb_ff};
				`A_RXD: s_axi_rdata <= {17'h0, rbd_ff, rst_ff == RX_HUNT,
					rerr_ff, rclose_ff, rval_ff, rxb_ff};
				`A_STAT: s_axi_rdata <= {28'h0, ev_ff[3:2], s2_ff[1:0]}; // [R02]
				`A_MASK: s_axi_rdata <= {28'h0, mask_ff};
				`A_BCHK: s_axi_rdata <= {16'h0, bc_ff};
				default: begin
					if (s_axi_araddr[7:5] == 3'b010 &&
						s_axi_araddr[1:0] == 2'b00) begin
						s_axi_rdata <= {16'h0, tab_ff[16*s_axi_araddr[4:2] +: 16]};
					end else begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/bisync_port_chk.sv ====
// port checker: register bus answers, reset state and line timing
`timescale 1ns/100ps
`default_nettype none
module bisync_port_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_clk,
	input wire logic txd,
	input wire logic irq
);
	logic [3:0] since_fall_ff;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles since the raw link clock was seen falling, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			since_fall_ff <= 4'hf;
		end else if ($fell(tx_clk)) begin
			since_fall_ff <= 4'h0;
		end else if (since_fall_ff != 4'hf) begin
			since_fall_ff <= since_fall_ff + 4'h1;
		end
	end
	// a write is taken with both channels together
	sequence wr_take;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	sequence rd_take;
		s_axi_arvalid && !s_axi_rvalid;
	endsequence
	a_write_answer: assert property (wr_take |=> s_axi_bvalid)
		else $error("write response missing");
	a_write_pair: assert property (s_axi_awvalid && s_axi_awready |-> s_axi_wready)
		else $error("address taken without data");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data missing");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data not held");
	a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	// reset check runs while reset is applied, so no disable
	a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && txd)
		else $error("outputs not quiet in reset");
	// a rising-edge launch would show up six or more cycles after the fall
	a_txd_on_fall: assert property ($changed(txd) |-> since_fall_ff < 4'h6)
		else $error("line bit changed away from falling edge");
endmodule
bind bisync_channel_controller bisync_port_chk i_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.tx_clk, .txd, .irq);
`default_nettype wire

// ==== verif/bisync_far_station.sv ====
// remote station: line clocks, fill-padded sender and line capture
`timescale 1ns/100ps
`default_nettype none
module bisync_far_station #(
	parameter logic [7:0] FILL = 8'h32
) (
	output logic tx_clk,
	output logic rx_clk,
	output logic rxd,
	input wire logic txd,
	output logic [31:0] win_ff
);
	logic [7:0] txq[$];
	logic [7:0] cur;
	// synchronous line clocks run free; offset keeps them off aclk edges
	initial begin
		tx_clk = 1'b0;
		rx_clk = 1'b0;
		#7;
		forever begin
			#80 tx_clk = ~tx_clk;
			rx_clk = ~rx_clk;
		end
	end
	// gaps would break character framing, so idle time carries fill chars
	initial begin
		rxd = 1'b1;
		forever begin
			cur = (txq.size() != 0) ? txq.pop_front() : FILL;
			for (int i = 0; i < 8; i++) begin
				@(negedge rx_clk);
				rxd = cur[i]; // lsb first
			end
		end
	end
	// newest bit enters at the top, so earlier chars sit low
	initial win_ff = '0;
	always @(posedge tx_clk) begin
		win_ff <= {txd, win_ff[31:1]};
	end
endmodule
`default_nettype wire

// ==== verif/bisync_channel_controller_tb.sv ====
// self-checking bench for the synchronous channel controller
`timescale 1ns/100ps
`default_nettype none
`include "bisync_consts.svh"
module bisync_channel_controller_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic cts_n = 1'b0, cd_n = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tx_clk, rx_clk, rxd, txd, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, v;
	logic [31:0] win;
	logic [15:0] r;
	logic [7:0] d;
	int err_count = 0, total_checks = 0, cyc = 0;
	always #10 aclk = ~aclk;
	bisync_channel_controller i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.tx_clk, .rx_clk, .rxd, .cts_n, .cd_n, .txd, .irq);
	bisync_far_station i_far (.tx_clk, .rx_clk, .rxd, .txd, .win_ff(win));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// ready strobes drop one edge early so the next call never clashes
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// two chars to the remote sender, then wait past the second's last bit
	task automatic sendc(input logic [7:0] a, input logic [7:0] b);
		i_far.txq.push_back(a);
		i_far.txq.push_back(b);
		while (i_far.txq.size() != 0) @(posedge aclk);
		repeat (80) @(posedge aclk);
	endtask
	// true if the char pair sits at any alignment in the captured line
	// window spans two full pair periods, so any phase of the pair shows
	function automatic logic [31:0] hit(input logic [31:0] w,
		input logic [15:0] p);
		for (int k = 0; k < 17; k++) begin
			if (w[k+:16] === p) return 32'h1;
		end
		return 32'h0;
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hang guard, well beyond the few thousand cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(42436));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`A_TAB);
		chk(v, 32'h0000_8000);
		rd(8'h3C);
		chk(32'(rsp), 32'h2);
		// protocol off: commands must not land
		wr(`A_CMD, `CMD_STOP);
		rd(`A_CMD);
		chk(v & 32'h1, 32'h0);
		for (int i = 0; i < 8; i++) begin
			r = 16'($urandom);
			wr(`A_TAB + 8'(i * 4), {16'h0, r});
			rd(`A_TAB + 8'(i * 4));
			chk(v, {16'h0, r});
		end
		// low-byte strobe leaves the valid flag alone
		wr(`A_SYNC, 32'h0000_8032);
		s_axi_wstrb <= 4'h1;
		wr(`A_SYNC, 32'h0000_0011);
		s_axi_wstrb <= 4'h3;
		rd(`A_SYNC);
		chk(v, 32'h0000_8011);
		wr(`A_SYNC, 32'h0000_8032);
		wr(`A_SYNP, 32'h0000_3232);
		wr(`A_ESC, 32'h0000_8010);
		wr(`A_TAB, 32'h0000_2003);
		wr(`A_TAB + 8'h04, 32'h0000_8000);
		wr(`A_MASK, 32'h0000_000C);
		wr(`A_MODE, 32'h0000_000B);
		repeat (300) @(posedge aclk);
		rd(`A_RXD);
		chk(v & 32'h7800, 32'h0);
		d = 8'h80 | 8'($urandom);
		sendc(d, 8'h32);
		rd(`A_RXD);
		chk(v & 32'h3FF, {22'h0, 2'b01, d});
		repeat (100) @(posedge aclk);
		rd(`A_RXD);
		chk(v & 32'h100, 32'h0);
		wr(`A_CMD, `CMD_RSTBC);
		rd(`A_BCHK);
		chk(v, 32'h0);
		wr(`A_STAT, 32'h0000_000C);
		wr(`A_CMD, `CMD_HUNT);
		rd(`A_RXD);
		chk(v & 32'h7800, 32'h1800);
		rd(`A_STAT);
		chk(v & 32'h8, 32'h8);
		chk(32'(irq), 32'h1);
		// carrier change: event, mask and clear
		wr(`A_STAT, 32'h0000_000C);
		cd_n <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(`A_STAT);
		chk(v & 32'h5, 32'h5);
		chk(32'(irq), 32'h1);
		wr(`A_MASK, 32'h0);
		chk(32'(irq), 32'h0);
		cd_n <= 1'b0;
		repeat (10) @(posedge aclk);
		wr(`A_STAT, 32'h0000_000C);
		rd(`A_STAT);
		chk(v & 32'hC, 32'h0);
		wr(`A_MASK, 32'h0000_000C);
		// transparent receive, escape pairs
		wr(`A_MODE, 32'h0000_002B);
		repeat (300) @(posedge aclk);
		sendc(8'h10, 8'h10);
		rd(`A_RXD);
		chk(v & 32'h7FF, 32'h110);
		sendc(8'h10, 8'h32);
		rd(`A_RXD);
		chk(v & 32'h100, 32'h0);
		wr(`A_STAT, 32'h0000_000C);
		sendc(8'h10, 8'h03);
		rd(`A_RXD);
		chk(v & 32'hFFF, 32'hB03);
		rd(`A_STAT);
		chk(v & 32'h8, 32'h8);
		repeat (300) @(posedge aclk);
		sendc(8'h10, 8'hC1);
		rd(`A_RXD);
		chk(v & 32'h600, 32'h600);
		// escape flag clear: the escape char is plain data
		wr(`A_ESC, 32'h0000_0010);
		wr(`A_CMD, `CMD_HUNT);
		repeat (300) @(posedge aclk);
		sendc(8'h10, 8'h32);
		rd(`A_RXD);
		chk(v & 32'h3FF, 32'h310);
		// transmitter: first descriptor, stop, restart
		wr(`A_MODE, 32'h0000_0007);
		rd(`A_CMD);
		chk(v & 32'hF, 32'h0);
		wr(`A_TXD, {23'h0, 1'b1, 8'($urandom)});
		repeat (300) @(posedge aclk);
		rd(`A_TXD);
		chk(v & 32'h200, 32'h0);
		wr(`A_CMD, `CMD_STOP);
		repeat (300) @(posedge aclk);
		rd(`A_CMD);
		chk(v & 32'hF, 32'h3);
		chk(hit(win, 16'h3232), 32'h1);
		wr(`A_MODE, 32'h0000_0013); // transmitter off while stopped
		wr(`A_CMD, `CMD_RESTART);
		wr(`A_MODE, 32'h0000_0017);
		rd(`A_CMD);
		chk(v & 32'hF, 32'h2);
		rd(`A_MODE);
		chk(v, 32'h0000_0017);
		// open message with no follow-up byte runs dry
		wr(`A_TXD, {24'h0, 8'($urandom)});
		repeat (300) @(posedge aclk);
		chk(hit(win, 16'h3210), 32'h1);
		rd(`A_CMD);
		chk(v & 32'hF, 32'h4);
		complete_run();
	end
endmodule
`default_nettype wire
